// file: verilog/mhd_defines.svh
// constants for the mic insert / hook switch event block
// assumes a 50 MHz system clock
`ifndef MHD_DEFINES_SVH
`define MHD_DEFINES_SVH
`define MHD_CLK_MHZ         50
`define MHD_SAMPLE_NS       1000
`define MHD_SAMPLE_CYC      (((`MHD_SAMPLE_NS * `MHD_CLK_MHZ) + 999) / 1000)
`define MHD_HOOK_SAMPLES    10
`define MHD_INSERT_SAMPLES  10
`define MHD_ADDR_STATUS     4'h0
`define MHD_ADDR_MASK       4'h1
`define MHD_ADDR_CTRL       4'h2
`define MHD_ADDR_STATE      4'h3
`define MHD_BIT_INSERT      0
`define MHD_BIT_HOOK        1
`define MHD_CTRL_RST        8'h00
`define MHD_MASK_RST        8'h00
`define MHD_GPIO_SEL_INSERT 1'b0
`endif

// file: verilog/mhd_pkg.sv
// types for the mic insert / hook switch event block
// assumes mhd_defines.svh constants alongside
package mhd_pkg;
  typedef enum logic [1:0] {
    mhd_st_idle,
    mhd_st_count,
    mhd_st_settled
  } mhd_filt_t;
endpackage : mhd_pkg

// file: verilog/mhd_events.sv
// mic insert and hook switch debounce with sticky event flags
// assumes comparator inputs synchronous to clk, host on a simple port
//
// Chosen here: the strobed register port and the address map.
`include "mhd_defines.svh"
module mhd_events (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // comparator samples
  input  wire logic       mic_present_raw,
  input  wire logic       hook_above_raw,
  // register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // outputs
  output logic            irq,
  output logic            gpio_state
);
  localparam int SCW = 6;
  localparam logic [SCW-1:0] SAMPLE_LAST = SCW'(`MHD_SAMPLE_CYC - 1);

  logic [SCW-1:0] sample_cnt;
  logic           sample_tick;
  logic [1:0]     raw_in;
  logic [1:0]     steady;
  logic [3:0]     run_cnt [2];
  mhd_pkg::mhd_filt_t filt_st [2];
  logic [1:0]     status;
  logic [1:0]     mask;
  logic           insert_detect_polarity;
  logic           hook_detect_polarity;
  logic           gpio_sel;
  logic [1:0]     polarity;
  logic [1:0]     match;
  logic [1:0]     match_q;
  logic [1:0]     event_set;

  // sample strobe for both debounce filters
  assign sample_tick = (sample_cnt == SAMPLE_LAST);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_cnt <= '0;
    end else begin
      sample_cnt <= sample_tick ? '0 : sample_cnt + SCW'(1);
    end
  end

  assign raw_in[`MHD_BIT_INSERT] = mic_present_raw;
  assign raw_in[`MHD_BIT_HOOK]   = hook_above_raw;

  function automatic logic [3:0] mhd_limit(input int idx);
    return (idx == `MHD_BIT_HOOK) ? 4'(`MHD_HOOK_SAMPLES) : 4'(`MHD_INSERT_SAMPLES);
  endfunction : mhd_limit

  // debounce: steady changes after limit consecutive differing samples
  for (genvar i = 0; i < 2; i++) begin : g_filt
    logic differ;
    logic [3:0] next_cnt;
    assign differ   = raw_in[i] != steady[i];
    assign next_cnt = run_cnt[i] + 4'h1;
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        run_cnt[i] <= 4'h0;
        steady[i]  <= 1'b0;
        filt_st[i] <= mhd_pkg::mhd_st_idle;
      end else if (sample_tick) begin
        case (filt_st[i])
          mhd_pkg::mhd_st_idle: begin
            if (differ) begin
              run_cnt[i] <= 4'h1;
              filt_st[i] <= mhd_pkg::mhd_st_count;
            end
          end
          mhd_pkg::mhd_st_count: begin
            if (!differ) begin
              run_cnt[i] <= 4'h0;
              filt_st[i] <= mhd_pkg::mhd_st_idle;
            end else if (next_cnt == mhd_limit(i)) begin
              run_cnt[i] <= 4'h0;
              steady[i]  <= raw_in[i];
              filt_st[i] <= mhd_pkg::mhd_st_settled;
            end else begin
              run_cnt[i] <= next_cnt;
            end
          end
          mhd_pkg::mhd_st_settled: begin
            // a new run may start on the very next sample
            if (differ) begin
              run_cnt[i] <= 4'h1;
              filt_st[i] <= mhd_pkg::mhd_st_count;
            end else begin
              filt_st[i] <= mhd_pkg::mhd_st_idle;
            end
          end
          default: begin
            filt_st[i] <= mhd_pkg::mhd_st_idle;
          end
        endcase
      end
    end
  end

  // polarity names the level armed from: event when steady leaves it
  assign polarity  = {hook_detect_polarity, insert_detect_polarity};
  assign match     = steady ^ polarity;
  assign event_set = match & ~match_q;

  // register decode
  logic wr_mask, wr_ctrl, rd_status;
  assign wr_mask   = wr && (addr == `MHD_ADDR_MASK);
  assign wr_ctrl   = wr && (addr == `MHD_ADDR_CTRL);
  assign rd_status = rd && (addr == `MHD_ADDR_STATUS);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      match_q <= 2'b11;
      status  <= 2'b00;
    end else begin
      match_q <= match;
      // set wins over read clear
      status  <= (rd_status ? 2'b00 : status) | event_set;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask                   <= 2'(`MHD_MASK_RST);
      insert_detect_polarity <= 1'b0;
      hook_detect_polarity   <= 1'b0;
      gpio_sel               <= `MHD_GPIO_SEL_INSERT;
    end else begin
      if (wr_mask) mask <= wdata[1:0];
      if (wr_ctrl) begin
        insert_detect_polarity <= wdata[0];
        hook_detect_polarity   <= wdata[1];
        gpio_sel               <= wdata[2];
      end
    end
  end

  logic [7:0] next_rdata;
  always_comb begin
    case (addr)
      `MHD_ADDR_STATUS: next_rdata = {6'h00, status};
      `MHD_ADDR_MASK:   next_rdata = {6'h00, mask};
      `MHD_ADDR_CTRL:   next_rdata = {5'h00, gpio_sel, hook_detect_polarity,
                                      insert_detect_polarity};
      `MHD_ADDR_STATE:  next_rdata = {6'h00, steady};
      default:          next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata      <= 8'h00;
      gpio_state <= 1'b0;
    end else begin
      rdata      <= rd ? next_rdata : 8'h00;
      gpio_state <= gpio_sel ? steady[`MHD_BIT_HOOK] : steady[`MHD_BIT_INSERT];
    end
  end

  assign irq = |(status & mask);

  // checks
  // checker helper: samples since the hook input last changed
  logic       hook_last;
  logic [4:0] hook_same;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hook_last <= 1'b0;
      hook_same <= 5'h00;
    end else if (sample_tick) begin
      hook_last <= hook_above_raw;
      if (hook_above_raw != hook_last) begin
        hook_same <= 5'h01;
      end else if (hook_same != 5'h1f) begin
        hook_same <= hook_same + 5'h01;
      end
    end
  end

  hook_press_run_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(steady[1]) |-> hook_last && (hook_same >= 5'h0a)) else $error("hook press too early");
  hook_release_run_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(steady[1]) |-> !hook_last && (hook_same >= 5'h0a)) else $error("hook release too early");
  hook_press_lag_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(steady[1]) |-> $past(hook_above_raw)) else $error("hook rose without press");
  flag_sticky_a: assert property (@(posedge clk) disable iff (!arst_n)
    status[0] && !rd_status |=> status[0]) else $error("insert flag dropped");
  flag_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    event_set[1] |=> status[1]) else $error("hook flag not set");
  gpio_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
    !gpio_sel && $changed(steady[0]) |=> gpio_state == steady[0])
    else $error("gpio lag wrong");
  steady_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !sample_tick |=> $stable(steady)) else $error("steady moved off tick");
  hook_ten_a: assert property (@(posedge clk) disable iff (!arst_n)
    run_cnt[1] <= 4'(`MHD_HOOK_SAMPLES)) else $error("hook count overrun");
  irq_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_mask && (wdata[1:0] == 2'b00) |=> !irq) else $error("irq not masked");
  ins_sets_a: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(steady[0]) |-> $past(mic_present_raw) == steady[0])
    else $error("insert state moved off sample");
  insert_cov: cover property (@(posedge clk) $rose(steady[0]));
  hook_cov: cover property (@(posedge clk) $rose(steady[1]));
  release_cov: cover property (@(posedge clk) $fell(steady[1]));
  irq_cov: cover property (@(posedge clk) $rose(irq));
endmodule : mhd_events

// file: verif/mhd_host.sv
// host-side register master for the event block
// assumes the slave samples strobes on the rising edge of clk
module mhd_host (
  // register port
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output logic      [3:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {addr, wdata, wr, rd} = '0;
  end
  // released lines show inverted values
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk) {addr, wdata, wr} <= {~a, ~d, 1'b0};
  endtask : put
  task automatic get(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) {addr, rd} <= {~a, 1'b0};
    @(posedge clk) d = rdata;
  endtask : get
endmodule : mhd_host

// file: verif/tb.sv
// self-checking bench for the mic insert / hook switch event block
// assumes mhd_host drives the register port
`include "mhd_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk;
  logic       arst_n;
  logic       mic_present_raw;
  logic       hook_above_raw;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       irq;
  logic       gpio_state;
  logic [7:0] got;
  int         mismatches;
  int         checks_done;
  int         seed;
  mhd_events dut (.clk(clk), .arst_n(arst_n), .mic_present_raw(mic_present_raw),
    .hook_above_raw(hook_above_raw), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .gpio_state(gpio_state));
  mhd_host host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [7:0] ev(input logic hook);
    return hook ? 8'h02 : 8'h01;
  endfunction : ev
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    host.get(a, got);
    chk(got, exp);
  endtask : rchk
  task automatic pins(input logic irq_e, input logic gpio_e);
    @(negedge clk);
    chk({6'h00, irq, gpio_state}, {6'h00, irq_e, gpio_e});
  endtask : pins
  task automatic wait_smp(input int n);
    repeat (n * `MHD_SAMPLE_CYC) @(posedge clk);
  endtask : wait_smp
  // raw line moves, steady state must lag ten samples
  task automatic event_run(input logic hook, input logic lvl, input logic [1:0] st);
    if (hook) hook_above_raw <= lvl;
    else mic_present_raw <= lvl;
    wait_smp(8);
    rchk(`MHD_ADDR_STATE, {6'h00, st ^ (hook ? 2'b10 : 2'b01)});
    wait_smp(4);
    pins(1'b1, hook ? st[1] : st[0]);
    host.put(`MHD_ADDR_MASK, 8'h00);
    pins(1'b0, hook ? st[1] : st[0]);
    host.put(`MHD_ADDR_MASK, 8'h03);
    rchk(`MHD_ADDR_STATE, {6'h00, st});
    rchk(`MHD_ADDR_STATUS, ev(hook));
    rchk(`MHD_ADDR_STATUS, 8'h00);
    $display("event test done hook %0d level %0d", hook, lvl);
  endtask : event_run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end
  initial begin
    seed = 32'h383e19be;
    {mic_present_raw, hook_above_raw, arst_n} = '0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    pins(1'b0, 1'b0);
    rchk(`MHD_ADDR_CTRL, `MHD_CTRL_RST);
    rchk(`MHD_ADDR_MASK, `MHD_MASK_RST);
    rchk(4'hf, 8'h00);
    host.put(`MHD_ADDR_STATUS, 8'hff);
    rchk(`MHD_ADDR_STATUS, 8'h00);
    host.put(`MHD_ADDR_MASK, 8'h03);
    host.put(`MHD_ADDR_CTRL, 8'h00);
    $display("reset test done");
    // short random bounce on the jack, then one low sample to restart
    repeat (6) begin
      mic_present_raw <= 1'($random(seed));
      wait_smp(1);
    end
    mic_present_raw <= 1'b0;
    wait_smp(1);
    rchk(`MHD_ADDR_STATUS, 8'h00);
    event_run(1'b0, 1'b1, 2'b01);
    host.put(`MHD_ADDR_CTRL, 8'h05);
    rchk(`MHD_ADDR_STATUS, 8'h00);
    // runs shorter than ten samples, broken by one low sample
    repeat (2) begin
      hook_above_raw <= 1'b1;
      wait_smp(7);
      hook_above_raw <= 1'b0;
      wait_smp(1);
    end
    rchk(`MHD_ADDR_STATUS, 8'h00);
    event_run(1'b1, 1'b1, 2'b11);
    host.put(`MHD_ADDR_CTRL, 8'h07);
    event_run(1'b1, 1'b0, 2'b01);
    host.put(`MHD_ADDR_CTRL, 8'h01);
    event_run(1'b0, 1'b0, 2'b00);
    host.put(`MHD_ADDR_CTRL, 8'h00);
    rchk(`MHD_ADDR_STATUS, 8'h00);
    end_of_test();
  end
endmodule : tb
